// File: rtl/ssm_defs.svh
// Purpose: constants of the single step monitor
// Assumes: ahb-lite word registers
// Notes:   offsets are byte addresses
// Functional notes
// - in step mode, halt after the instruction at the stop address
// - in step mode, stop command halts after the current instruction
// - each advance while halted lets exactly one instruction run
// - after each instruction show memory word or accumulator, as selected
// - also show instruction word or its address, as selected
// - controls go to every channel, only one channel is observed
// - halt mode drives the halt control line on either stop condition
// - while halted, memory may be written or read back by hand
// - restart resumes free running or single step, as selected
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSM_OFF_CTRL      8'h00
`define SSM_OFF_STOP_ADDR 8'h04
`define SSM_OFF_CMD       8'h08
`define SSM_OFF_MEM_ADDR  8'h0c
`define SSM_OFF_MEM_WDATA 8'h10
`define SSM_OFF_MEM_RDATA 8'h14
`define SSM_OFF_DISP_DATA 8'h18
`define SSM_OFF_DISP_INST 8'h1c
`define SSM_OFF_STATUS    8'h20
// ----------------------------------------
// ctrl fields
// ----------------------------------------
`define SSM_CTRL_STEP     0
`define SSM_CTRL_HALT     1
`define SSM_CTRL_ADDRSTOP 2
`define SSM_CTRL_DATASEL  3
`define SSM_CTRL_INSTSEL  4
`define SSM_CTRL_CHAN     5
`define SSM_CTRL_RSTEP    7
`define SSM_CTRL_RESET    8'h00
// ----------------------------------------
// cmd fields
// ----------------------------------------
`define SSM_CMD_STOP      0
`define SSM_CMD_ADVANCE   1
`define SSM_CMD_RELEASE   2
`define SSM_CMD_MEMWR     3
`define SSM_CMD_MEMRD     4
`endif

// File: rtl/ssm_pkg.sv
// Purpose: types of the single step monitor
// Assumes: nothing
// Notes:   one-hot states
package ssm_pkg;
  typedef enum logic [3:0] {
    SSM_RUN    = 4'b0001,
    SSM_HALTED = 4'b0010,
    SSM_STEP   = 4'b0100,
    SSM_MEM    = 4'b1000
  } ssm_state_t;
endpackage

// File: rtl/ssm_monitor.sv
// Purpose: single step monitor for a triple channel computer
// Assumes: computer signals synchronous to clk_sys
// Notes:   one register file over ahb-lite, zero wait states
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ssm_defs.svh"

module ssm_monitor #(
  parameter int CH = 3,
  parameter int AW = 12,
  parameter int DW = 28
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // computer, observed side
  input  wire logic [CH-1:0]    cpu_instr_done,
  input  wire logic [CH*AW-1:0] cpu_instr_addr,
  input  wire logic [CH*DW-1:0] cpu_instr_word,
  input  wire logic [CH*DW-1:0] cpu_mem_word,
  input  wire logic [CH*DW-1:0] cpu_acc,
  input  wire logic [CH*DW-1:0] cpu_mem_rdata,
  input  wire logic [CH-1:0]    cpu_mem_ack,
  // computer, control side
  output logic [CH-1:0]         step_hold,
  output logic [CH-1:0]         halt_control_line,
  output logic [CH-1:0]         mem_wr,
  output logic [CH-1:0]         mem_rd,
  output logic [AW-1:0]         mem_addr,
  output logic [DW-1:0]         mem_wdata,
  output logic [DW-1:0]         disp_data,
  output logic [DW-1:0]         disp_instr
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (CH < 1 || CH > 4 || AW < 1 || AW > 32 || DW < 1 || DW > 32) begin : g_bad
    $error("ssm_monitor: unsupported parameters");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    ssm_pkg::ssm_state_t st;
    logic [7:0]          ctrl;
    logic [AW-1:0]       stop_addr;
    logic                stop_pend;
    logic                mem_is_wr;
    logic [AW-1:0]       maddr;
    logic [DW-1:0]       mwdata;
    logic [DW-1:0]       mrdata;
    logic [DW-1:0]       ddata;
    logic [DW-1:0]       dinst;
    logic [CH-1:0]       hold;
    logic [CH-1:0]       halt;
    logic [CH-1:0]       wr;
    logic [CH-1:0]       rd;
    logic                aw_pend;
    logic [7:0]          aw_off;
    logic [31:0]         rdata;
  } ssm_regs_t;

  ssm_regs_t s_reg;
  ssm_regs_t s_next;

  // ----------------------------------------
  // observed channel
  // ----------------------------------------
  logic [1:0]    chan;
  logic          obs_done;
  logic          obs_ack;
  logic [AW-1:0] obs_addr;
  logic [DW-1:0] obs_iword;
  logic [DW-1:0] obs_mword;
  logic [DW-1:0] obs_acc;
  logic [DW-1:0] obs_mrd;

  // a channel number beyond the machine falls back to channel 0
  always_comb begin
    chan = s_reg.ctrl[`SSM_CTRL_CHAN +: 2];
    if (32'(chan) >= CH) begin
      chan = 2'h0;
    end
    obs_done  = cpu_instr_done[chan];
    obs_ack   = cpu_mem_ack[chan];
    obs_addr  = cpu_instr_addr[32'(chan)*AW +: AW];
    obs_iword = cpu_instr_word[32'(chan)*DW +: DW];
    obs_mword = cpu_mem_word[32'(chan)*DW +: DW];
    obs_acc   = cpu_acc[32'(chan)*DW +: DW];
    obs_mrd   = cpu_mem_rdata[32'(chan)*DW +: DW];
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic        a_valid;
  logic        a_wr;
  logic        w_now;
  logic [7:0]  w_off;
  logic [31:0] wd;
  logic        c_stop;
  logic        c_adv;
  logic        c_rel;
  logic        c_mwr;
  logic        c_mrd;
  logic        addr_hit;
  logic        stop_now;

  always_comb begin
    a_valid = hsel && hready && htrans[1];
    a_wr    = a_valid && hwrite;
    w_now   = s_reg.aw_pend;
    w_off   = s_reg.aw_off;
    wd      = hwdata;
    c_stop  = w_now && (w_off == `SSM_OFF_CMD) && wd[`SSM_CMD_STOP];
    c_adv   = w_now && (w_off == `SSM_OFF_CMD) && wd[`SSM_CMD_ADVANCE];
    c_rel   = w_now && (w_off == `SSM_OFF_CMD) && wd[`SSM_CMD_RELEASE];
    c_mwr   = w_now && (w_off == `SSM_OFF_CMD) && wd[`SSM_CMD_MEMWR];
    c_mrd   = w_now && (w_off == `SSM_OFF_CMD) && wd[`SSM_CMD_MEMRD];
    // address stop looks at the instruction just finished
    addr_hit = s_reg.ctrl[`SSM_CTRL_ADDRSTOP] && (obs_addr == s_reg.stop_addr);
    stop_now = obs_done && (addr_hit || s_reg.stop_pend || c_stop);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next         = s_reg;
    s_next.aw_pend = a_wr;
    s_next.aw_off  = haddr[7:0];
    s_next.wr      = '0;
    s_next.rd      = '0;

    // register writes land in the data phase
    if (w_now) begin
      case (w_off)
        `SSM_OFF_CTRL:      s_next.ctrl      = wd[7:0];
        `SSM_OFF_STOP_ADDR: s_next.stop_addr = wd[AW-1:0];
        `SSM_OFF_MEM_ADDR:  s_next.maddr     = wd[AW-1:0];
        `SSM_OFF_MEM_WDATA: s_next.mwdata    = wd[DW-1:0];
        default: ;
      endcase
    end

    // display follows every instruction of the observed channel
    if (obs_done) begin
      s_next.ddata = s_reg.ctrl[`SSM_CTRL_DATASEL] ? obs_acc : obs_mword;
      s_next.dinst = s_reg.ctrl[`SSM_CTRL_INSTSEL] ?
                     DW'(obs_addr) : obs_iword;
    end

    // stop request clear by the halt wins over its set
    if (c_stop && s_reg.st == ssm_pkg::SSM_RUN) begin
      s_next.stop_pend = 1'b1;
    end

    case (s_reg.st)
      ssm_pkg::SSM_RUN: begin
        if (stop_now) begin
          s_next.st        = ssm_pkg::SSM_HALTED;
          s_next.stop_pend = 1'b0;
        end
      end
      ssm_pkg::SSM_HALTED: begin
        // nothing runs here without an explicit command
        if (c_adv) begin
          s_next.st = ssm_pkg::SSM_STEP;
        end else if (c_rel) begin
          s_next.st = s_reg.ctrl[`SSM_CTRL_RSTEP] ?
                      ssm_pkg::SSM_STEP : ssm_pkg::SSM_RUN;
        end else if (c_mwr || c_mrd) begin
          s_next.st        = ssm_pkg::SSM_MEM;
          s_next.mem_is_wr = c_mwr;
          s_next.wr        = {CH{c_mwr}};
          s_next.rd        = {CH{!c_mwr}};
        end
      end
      ssm_pkg::SSM_STEP: begin
        if (obs_done) begin
          s_next.st        = ssm_pkg::SSM_HALTED;
          s_next.stop_pend = 1'b0;
        end
      end
      ssm_pkg::SSM_MEM: begin
        s_next.wr = {CH{s_reg.mem_is_wr}};
        s_next.rd = {CH{!s_reg.mem_is_wr}};
        if (obs_ack) begin
          s_next.wr = '0;
          s_next.rd = '0;
          s_next.st = ssm_pkg::SSM_HALTED;
          if (!s_reg.mem_is_wr) begin
            s_next.mrdata = obs_mrd;
          end
        end
      end
      default: begin
        s_next.st = ssm_pkg::SSM_RUN;
      end
    endcase

    // hold every channel while stopped; the halt line is the alternative
    if (s_next.st == ssm_pkg::SSM_HALTED || s_next.st == ssm_pkg::SSM_MEM) begin
      s_next.hold = {CH{s_next.ctrl[`SSM_CTRL_STEP] &&
                        !s_next.ctrl[`SSM_CTRL_HALT]}};
      s_next.halt = {CH{s_next.ctrl[`SSM_CTRL_HALT]}};
    end else begin
      s_next.hold = '0;
      s_next.halt = '0;
    end
    // with neither mode chosen a stop still holds, never free runs
    if ((s_next.st == ssm_pkg::SSM_HALTED || s_next.st == ssm_pkg::SSM_MEM) &&
        !s_next.ctrl[`SSM_CTRL_STEP] && !s_next.ctrl[`SSM_CTRL_HALT]) begin
      s_next.hold = {CH{1'b1}};
    end

    // read data is fetched in the address phase, shown in the data phase
    s_next.rdata = 32'h0;
    if (a_valid && !hwrite) begin
      case (haddr[7:0])
        `SSM_OFF_CTRL:      s_next.rdata = 32'(s_reg.ctrl);
        `SSM_OFF_STOP_ADDR: s_next.rdata = 32'(s_reg.stop_addr);
        `SSM_OFF_MEM_ADDR:  s_next.rdata = 32'(s_reg.maddr);
        `SSM_OFF_MEM_WDATA: s_next.rdata = 32'(s_reg.mwdata);
        `SSM_OFF_MEM_RDATA: s_next.rdata = 32'(s_reg.mrdata);
        `SSM_OFF_DISP_DATA: s_next.rdata = 32'(s_reg.ddata);
        `SSM_OFF_DISP_INST: s_next.rdata = 32'(s_reg.dinst);
        `SSM_OFF_STATUS:    s_next.rdata = {28'h0, s_reg.st};
        default:            s_next.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_reg           <= '0;
      s_reg.st        <= ssm_pkg::SSM_RUN;
      s_reg.ctrl      <= `SSM_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero wait states, so ready is a fixed flop and response is tied to 0
  logic hready_reg;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hready_reg <= 1'b1;
    end else begin
      hready_reg <= 1'b1;
    end
  end

  assign hreadyout         = hready_reg;
  assign hresp             = 1'b0 & hready_reg;
  assign hrdata            = s_reg.rdata;
  assign step_hold         = s_reg.hold;
  assign halt_control_line = s_reg.halt;
  assign mem_wr            = s_reg.wr;
  assign mem_rd            = s_reg.rd;
  assign mem_addr          = s_reg.maddr;
  assign mem_wdata         = s_reg.mwdata;
  assign disp_data         = s_reg.ddata;
  assign disp_instr        = s_reg.dinst;

endmodule

// File: dv/ssm_asserts.sv
// Purpose: port checks of the monitor
// Assumes: bound into ssm_monitor
// Notes:   channel 0 stands for all
`timescale 1ns/1ps
module ssm_asserts #(parameter int CH = 3) (
  input wire logic          clk_sys,
  input wire logic          reset,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input wire logic [31:0]   hwdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic [CH-1:0] cpu_instr_done,
  input wire logic [CH-1:0] cpu_mem_ack,
  input wire logic [CH-1:0] step_hold,
  input wire logic [CH-1:0] halt_control_line,
  input wire logic [CH-1:0] mem_wr
);
  // ------
  // writes that may move hold or halt
  // ------
  logic cmd_reg, ctl_reg, rel, rel_d_reg, any, cause;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_reg <= 1'b0;
      ctl_reg <= 1'b0;
      rel_d_reg <= 1'b0;
    end else begin
      cmd_reg <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h08;
      ctl_reg <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      rel_d_reg <= rel;
    end
  end
  // a ctrl write may swap hold for halt line
  assign rel = ctl_reg || (cmd_reg && (hwdata[1] || hwdata[2]));
  assign any = rel || rel_d_reg;
  assign cause = cpu_instr_done[0] || any;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_wait; mem_wr[0] && !cpu_mem_ack[0]; endsequence
  sequence s_ack; mem_wr[0] && cpu_mem_ack[0]; endsequence
  AST_BUS:
    assert property (hreadyout && !hresp) else $error("bus not okay");
  AST_ALL_CH:
    assert property ((&step_hold || !step_hold) && (&halt_control_line || !halt_control_line)
      && (&mem_wr || !mem_wr)) else $error("channels differ");
  AST_HOLD_CAUSE:
    assert property ($rose(step_hold[0]) |-> $past(cause)) else $error("hold without done");
  AST_HALT_CAUSE:
    assert property ($rose(halt_control_line[0]) |-> $past(cause)) else $error("halt without done");
  AST_KEEP:
    assert property ($fell(step_hold[0]) || $fell(halt_control_line[0]) |-> $past(any))
      else $error("hold dropped by itself");
  AST_MEM_KEEP:
    assert property (s_wait |=> mem_wr[0]) else $error("mem request dropped");
  AST_MEM_DROP:
    assert property (s_ack |=> !mem_wr[0]) else $error("mem request stuck");
  AST_EXCL:
    assert property (!(step_hold[0] && halt_control_line[0])) else $error("hold and halt both");
endmodule

// File: dv/ssm_cpu_model.sv
// Purpose: lockstep three channel computer
// Assumes: one instruction in three clocks unless held
// Notes:   top nibble f makes a word a jump via its operand
`timescale 1ns/1ps
module ssm_cpu_model (
  input  wire logic [2:0]  clk_sys_unused_n,
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [2:0]  step_hold,
  input  wire logic [2:0]  halt_control_line,
  input  wire logic [2:0]  mem_wr,
  input  wire logic [2:0]  mem_rd,
  input  wire logic [11:0] mem_addr,
  input  wire logic [27:0] mem_wdata,
  output logic      [2:0]  cpu_instr_done,
  output logic      [35:0] cpu_instr_addr,
  output logic      [83:0] cpu_instr_word,
  output logic      [83:0] cpu_mem_word,
  output logic      [83:0] cpu_acc,
  output logic      [83:0] cpu_mem_rdata,
  output logic      [2:0]  cpu_mem_ack
);
  logic [27:0] mem [0:4095];
  logic [27:0] rd;
  logic [11:0] pc;
  logic [1:0]  cnt;
  // released data lines show the inverse of the last word
  assign cpu_mem_rdata = {3{cpu_mem_ack[0] ? rd : ~rd}};
  initial for (int i = 0; i < 4096; i++) mem[i] = 28'(i);
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pc <= 12'h0;
      cnt <= 2'h0;
      cpu_instr_done <= 3'h0;
      cpu_mem_ack <= 3'h0;
    end else begin
      cpu_instr_done <= 3'h0;
      cpu_mem_ack <= {3{(mem_wr[0] || mem_rd[0]) && !cpu_mem_ack[0]}};
      rd <= mem[mem_addr];
      if (mem_wr[0] && !cpu_mem_ack[0])
        mem[mem_addr] <= mem_wdata;
      if (!step_hold[0] && !halt_control_line[0]) begin
        cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
        if (cnt == 2'h2) begin
          cpu_instr_done <= 3'h7;
          pc <= (mem[pc][27:24] == 4'hf) ? mem[mem[pc][11:0]][11:0] : pc + 12'h1;
          for (int c = 0; c < 3; c++) begin
            cpu_instr_addr[c*12 +: 12] <= pc;
            cpu_instr_word[c*28 +: 28] <= mem[pc];
            cpu_mem_word[c*28 +: 28] <= mem[mem[pc][11:0]];
            cpu_acc[c*28 +: 28] <= {4'h0, 4'(c), 8'h0, pc};
          end
        end
      end
    end
  end
endmodule

// File: dv/ssm_monitor_bench.sv
// Purpose: self-checking bench of the monitor
// Assumes: lockstep computer model beyond it
// Notes:   program word at address a is a
`timescale 1ns/1ps
module ssm_monitor_bench;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv;
  logic        hreadyout, hresp;
  logic [2:0]  cpu_instr_done, cpu_mem_ack, step_hold, halt_control_line, mem_wr, mem_rd;
  logic [35:0] cpu_instr_addr;
  logic [83:0] cpu_instr_word, cpu_mem_word, cpu_acc, cpu_mem_rdata;
  logic [11:0] mem_addr;
  logic [27:0] mem_wdata, disp_data, disp_instr;
  int          miscompares = 0;
  int          checks_done = 0;
  ssm_monitor u_dut (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_instr_done, .cpu_instr_addr,
    .cpu_instr_word, .cpu_mem_word, .cpu_acc, .cpu_mem_rdata, .cpu_mem_ack, .step_hold,
    .halt_control_line, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .disp_data, .disp_instr);
  ssm_cpu_model u_cpu (.clk_sys_unused_n(3'h0), .clk_sys, .reset, .step_hold,
    .halt_control_line, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .cpu_instr_done,
    .cpu_instr_addr, .cpu_instr_word, .cpu_mem_word, .cpu_acc, .cpu_mem_rdata, .cpu_mem_ack);
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // ------
  // single word transfer, read data left in rv
  // ------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  // two edges first, so an old hold has time to drop
  task automatic halted;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 400 && step_hold !== 3'h7 && halt_control_line !== 3'h7; i++)
      @(posedge clk_sys);
  endtask
  task automatic mem_put(input logic [11:0] a, input logic [27:0] d);
    bus(1'b1, 8'h0c, {20'h0, a});
    bus(1'b1, 8'h10, {4'h0, d});
    bus(1'b1, 8'h08, 32'h8);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_addr_stop;
    bus(1'b1, 8'h04, 32'd40);
    bus(1'b1, 8'h00, 32'h15);
    halted;
    chk(32'(step_hold), 32'h7);
    chk(32'(halt_control_line), 32'h0);
    chk(32'(disp_instr), 32'd40);
    chk(32'(disp_data), 32'd40);
    bus(1'b0, 8'h20, 32'h0);
    chk(rv, 32'h2);
  endtask
  task automatic t_advance;
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, 8'h00, {25'h0, 2'(c), 5'h1d});
      bus(1'b1, 8'h08, 32'h2);
      halted;
      chk(32'(disp_instr), 32'(41 + c));
      chk(32'(disp_data), 32'(41 + c + c * 32'h100000));
      repeat (20) @(posedge clk_sys);
      chk(32'(disp_instr), 32'(41 + c));
    end
  endtask
  task automatic t_mem;
    mem_put(12'd200, 28'habcdef);
    bus(1'b1, 8'h08, 32'h10);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, 8'h14, 32'h0);
    chk(rv, 32'habcdef);
    bus(1'b0, 8'h24, 32'h0);
    chk(rv, 32'h0);
  endtask
  task automatic t_restart;
    mem_put(12'd44, 28'hf00012c);
    mem_put(12'd300, 28'd500);
    bus(1'b1, 8'h00, 32'h91);
    bus(1'b1, 8'h08, 32'h4);
    halted;
    chk(32'(disp_instr), 32'd44);
    bus(1'b1, 8'h08, 32'h2);
    halted;
    chk(32'(disp_instr), 32'd500);
    bus(1'b1, 8'h04, 32'd502);
    bus(1'b1, 8'h00, 32'h16);
    bus(1'b1, 8'h08, 32'h4);
    halted;
    chk(32'(halt_control_line), 32'h7);
    chk(32'(disp_instr), 32'd502);
  endtask
  task automatic t_stop;
    logic [27:0] seen;
    bus(1'b1, 8'h00, 32'h11);
    bus(1'b1, 8'h08, 32'h4);
    repeat (10) @(posedge clk_sys);
    bus(1'b1, 8'h08, 32'h1);
    halted;
    seen = disp_instr;
    chk(32'(step_hold), 32'h7);
    repeat (20) @(posedge clk_sys);
    chk(32'(disp_instr), 32'(seen));
  endtask
  task automatic final_report;
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #500000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_addr_stop;
    t_advance;
    t_mem;
    t_restart;
    t_stop;
    final_report;
  end
endmodule
bind ssm_monitor ssm_asserts #(.CH(CH)) u_chk (.clk_sys, .reset, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hreadyout, .hresp, .cpu_instr_done, .cpu_mem_ack, .step_hold,
  .halt_control_line, .mem_wr);
